// ==== logic/cbt_balance_timer.sv ====
// cell balancing timer: setup and per-cell time registers over APB,
// seconds/minutes time base, odd/even sequencing and stop on fault
// assumes a synchronous APB master on sys_clk and fault inputs synchronous
// to sys_clk
`timescale 1ns/1ps

module cbt_balance_timer #(
   parameter int SEC_CYCLES = cbt_pkg::SECOND_CYCLES
) (
   input  wire logic                   sys_clk,
   input  wire logic                   rst,
   input  wire cbt_pkg::cbt_apb_req_t  apb_req,
   output logic                        pready,
   output logic [31:0]                 prdata,
   output logic                        pslverr,
   input  wire logic                   fault,
   input  wire logic                   thermal_shutdown,
   output logic [cbt_pkg::CELL_COUNT-1:0] balance_sw
);
   import cbt_pkg::*;

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   // pick the tick that matches a unit bit: 1 seconds, 0 minutes
   function automatic logic unit_tick(input logic unit_sec, input logic s_tick,
                                      input logic m_tick);
      return unit_sec ? s_tick : m_tick;
   endfunction

   // cells that belong to the group being balanced
   function automatic logic [CELL_COUNT-1:0] group_mask(input logic even);
      return even ? ~ODD_CELLS : ODD_CELLS;
   endfunction

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   logic [7:0]             setup;
   logic [7:0]             cell_time [CELL_COUNT];
   logic [TIME_W-1:0]      remain    [CELL_COUNT];
   logic [31:0]            sec_cnt;
   logic [5:0]             min_cnt;
   logic [DUTY_W-1:0]      duty_cnt;
   cbt_state_t             state;
   logic                   fault_stop;
   logic                   done;

   logic [7:0]             next_setup;
   logic [7:0]             next_cell_time [CELL_COUNT];
   logic [TIME_W-1:0]      next_remain    [CELL_COUNT];
   logic [31:0]            next_sec_cnt;
   logic [5:0]             next_min_cnt;
   logic [DUTY_W-1:0]      next_duty_cnt;
   cbt_state_t             next_state;
   logic                   next_fault_stop;
   logic                   next_done;
   logic                   next_pready;
   logic [31:0]            next_prdata;
   logic                   next_pslverr;
   logic [CELL_COUNT-1:0]  next_balance_sw;

   logic                   setup_phase;
   logic                   wr_en;
   logic [9:0]             idx;
   logic                   idx_cell;
   logic [2:0]             cell_sel;
   logic                   start_cmd;
   logic                   abort_cmd;
   logic                   sec_tick;
   logic                   min_tick;
   logic [CELL_COUNT-1:0]  left;
   logic                   odd_left;
   logic                   even_left;
   logic [1:0]             order;
   logic                   both_groups;
   logic                   halt;
   logic [CELL_COUNT-1:0]  cur_mask;
   logic [CELL_COUNT-1:0]  nxt_mask;

   // ----------------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------------
   // a write lands only on the edge where pready is seen high
   // the byte address is four times the register index
   assign setup_phase = apb_req.psel & ~apb_req.penable;
   assign wr_en       = apb_req.psel & apb_req.penable & pready & apb_req.pwrite;
   assign idx         = apb_req.paddr[ADDR_W-1:2];
   assign idx_cell    = (idx >= IDX_FIRST_CELL) && (idx < IDX_FIRST_CELL + 10'(CELL_COUNT));
   assign cell_sel    = 3'(idx - IDX_FIRST_CELL);
   assign start_cmd   = wr_en && idx == IDX_CTRL && apb_req.pwdata[CTRL_START_BIT];
   assign abort_cmd   = wr_en && idx == IDX_CTRL && apb_req.pwdata[CTRL_ABORT_BIT];
   assign order       = setup[SETUP_ORD_LSB +: 2];
   assign both_groups = order == ORD_ODD_EVEN || order == ORD_EVEN_ODD;
   // thermal shutdown always halts; other faults only with stop set
   assign halt        = thermal_shutdown | (fault & setup[SETUP_STOP_BIT]);

   // group masks of the running phase and of the phase being entered,
   // held as nets so that single cells can be picked out of them
   assign cur_mask    = group_mask(state == ST_EVEN);
   assign nxt_mask    = group_mask(next_state == ST_EVEN);

   // answer registers: pready in the first access cycle, unmapped errors
   // ctrl reads as zero; status shows the run as it stands
   always_comb begin
      next_pready  = setup_phase;
      next_pslverr = 1'b0;
      next_prdata  = 32'h0;
      if (setup_phase) begin
         if (idx == IDX_SETUP) begin
            next_prdata[7:0] = setup;
         end else if (idx_cell) begin
            next_prdata[7:0] = cell_time[cell_sel];
         end else if (idx == IDX_STATUS) begin
            next_prdata[STAT_BUSY_BIT]  = state != ST_IDLE;
            next_prdata[STAT_EVEN_BIT]  = state == ST_EVEN;
            next_prdata[STAT_FAULT_BIT] = fault_stop;
            next_prdata[STAT_DONE_BIT]  = done;
         end else if (idx != IDX_CTRL) begin
            next_pslverr = 1'b1;
         end
      end
   end

   // configuration registers
   always_comb begin
      next_setup = setup;
      for (int i = 0; i < CELL_COUNT; i++) begin
         next_cell_time[i] = cell_time[i];
      end
      if (wr_en && idx == IDX_SETUP) begin
         next_setup = apb_req.pwdata[7:0];
      end
      if (wr_en && idx_cell) begin
         next_cell_time[cell_sel] = apb_req.pwdata[7:0];
      end
   end

   // ----------------------------------------------------------------------
   // time base
   // ----------------------------------------------------------------------
   // seconds prescaler and minute counter run only while balancing
   // the prescaler restarts at every start, so the first tick of a run
   // comes one whole second after the start write
   assign sec_tick = state != ST_IDLE && sec_cnt == 32'(SEC_CYCLES - 1);
   assign min_tick = sec_tick && min_cnt == 6'(MINUTE_SECONDS - 1);

   // prescaler and minute counter
   always_comb begin
      next_sec_cnt = sec_cnt;
      next_min_cnt = min_cnt;
      if (state == ST_IDLE) begin
         next_sec_cnt = 32'h0;
         next_min_cnt = 6'h0;
      end else if (sec_tick) begin
         next_sec_cnt = 32'h0;
         next_min_cnt = min_tick ? 6'h0 : min_cnt + 6'h1;
      end else begin
         next_sec_cnt = sec_cnt + 32'h1;
      end
   end

   // ----------------------------------------------------------------------
   // sequencer and per-cell timers
   // ----------------------------------------------------------------------
   // which cells still have time to run, by group
   always_comb begin
      for (int i = 0; i < CELL_COUNT; i++) begin
         left[i] = remain[i] != '0;
      end
      odd_left  = |(left & ODD_CELLS);
      even_left = |(left & ~ODD_CELLS);
   end

   // phase sequencer: loads the timers at start, counts down, hands over
   always_comb begin
      next_state      = state;
      next_duty_cnt   = duty_cnt;
      next_fault_stop = fault_stop;
      next_done       = done;
      for (int i = 0; i < CELL_COUNT; i++) begin
         next_remain[i] = remain[i];
      end
      unique case (state)
         ST_IDLE: begin
            // a start is refused while a halt stands, so no switch closes
            // for even one cycle under thermal shutdown or a fault with stop set
            if (start_cmd && !halt) begin
               next_fault_stop = 1'b0;
               next_done       = 1'b0;
               next_duty_cnt   = '0;
               for (int i = 0; i < CELL_COUNT; i++) begin
                  next_remain[i] = cell_time[i][TIME_W-1:0];
               end
               // odd-first orders start on odd cells, the others on even
               next_state = (order == ORD_ODD || order == ORD_ODD_EVEN) ? ST_ODD
                                                                        : ST_EVEN;
            end
         end
         ST_ODD, ST_EVEN: begin
            // count down every active cell in its own unit
            for (int i = 0; i < CELL_COUNT; i++) begin
               if (cur_mask[i] && left[i]
                   && unit_tick(cell_time[i][CELL_UNIT_BIT], sec_tick, min_tick)) begin
                  next_remain[i] = remain[i] - 7'h1;
               end
            end
            if (unit_tick(setup[SETUP_UNIT_BIT], sec_tick, min_tick)) begin
               next_duty_cnt = duty_cnt + 4'h1;
            end
            // a group with no time left hands over at once, or ends the run
            if (state == ST_ODD && !odd_left) begin
               next_duty_cnt = '0;
               next_state    = (both_groups && even_left) ? ST_EVEN : ST_IDLE;
            end else if (state == ST_EVEN && !even_left) begin
               next_duty_cnt = '0;
               next_state    = (both_groups && odd_left) ? ST_ODD : ST_IDLE;
            end else if (both_groups && setup[SETUP_DUTY_LSB +: DUTY_W] != '0
                         && next_duty_cnt == setup[SETUP_DUTY_LSB +: DUTY_W]
                         && (state == ST_ODD ? even_left : odd_left)) begin
               // duty slice used up: hand over to the other group
               next_duty_cnt = '0;
               next_state    = state == ST_ODD ? ST_EVEN : ST_ODD;
            end
            // a run that runs out of time sets done
            if (next_state == ST_IDLE) begin
               next_done = 1'b1;
            end
            // a halt beats an abort in the same cycle and sets the fault flag
            if (halt) begin
               next_state      = ST_IDLE;
               next_fault_stop = 1'b1;
            end else if (abort_cmd) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // switch drive follows the next phase so it stays in step with the timers
   always_comb begin
      next_balance_sw = '0;
      for (int i = 0; i < CELL_COUNT; i++) begin
         if (next_state != ST_IDLE && nxt_mask[i]
             && next_remain[i] != '0) begin
            next_balance_sw[i] = 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------
   // all state held in one clocked process with synchronous reset
   // outputs are registered here too, so every port comes from a flop
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         setup      <= SETUP_RESET;
         sec_cnt    <= 32'h0;
         min_cnt    <= 6'h0;
         duty_cnt   <= '0;
         state      <= ST_IDLE;
         fault_stop <= 1'b0;
         done       <= 1'b0;
         pready     <= 1'b0;
         prdata     <= 32'h0;
         pslverr    <= 1'b0;
         balance_sw <= '0;
         for (int i = 0; i < CELL_COUNT; i++) begin
            cell_time[i] <= CELL_RESET;
            remain[i]    <= '0;
         end
      end else begin
         setup      <= next_setup;
         sec_cnt    <= next_sec_cnt;
         min_cnt    <= next_min_cnt;
         duty_cnt   <= next_duty_cnt;
         state      <= next_state;
         fault_stop <= next_fault_stop;
         done       <= next_done;
         pready     <= next_pready;
         prdata     <= next_prdata;
         pslverr    <= next_pslverr;
         balance_sw <= next_balance_sw;
         for (int i = 0; i < CELL_COUNT; i++) begin
            cell_time[i] <= next_cell_time[i];
            remain[i]    <= next_remain[i];
         end
      end
   end

endmodule

// ==== logic/cbt_pkg.sv ====
// package for the cell balancing timer: register map, fields, resets, timing
// assumes a 100 MHz system clock and an APB master with 32-bit data
package cbt_pkg;

   // ----------------------------------------------------------------------
   // register indexes (byte address is four times the index)
   // ----------------------------------------------------------------------
   localparam logic [9:0] IDX_SETUP      = 10'h10d; // balancing_setup
   localparam logic [9:0] IDX_FIRST_CELL      = 10'h10e; // first_cell_balance_time, further cells follow
   localparam logic [9:0] IDX_CTRL       = 10'h114; // start / abort commands
   localparam logic [9:0] IDX_STATUS     = 10'h115; // run state, read only
   localparam int         CELL_COUNT     = 6;
   localparam int         ADDR_W         = 12;

   // ----------------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------------
   localparam int         SETUP_UNIT_BIT = 7;
   localparam int         SETUP_DUTY_LSB = 3;
   localparam int         DUTY_W         = 4;
   localparam int         SETUP_STOP_BIT = 2;
   localparam int         SETUP_ORD_LSB  = 0;
   localparam int         CELL_UNIT_BIT  = 7;
   localparam int         TIME_W         = 7;
   localparam int         CTRL_START_BIT = 0;
   localparam int         CTRL_ABORT_BIT = 1;
   localparam int         STAT_BUSY_BIT  = 0;
   localparam int         STAT_EVEN_BIT  = 1;
   localparam int         STAT_FAULT_BIT = 2;
   localparam int         STAT_DONE_BIT  = 3;
   localparam logic [7:0] SETUP_RESET    = 8'h00;
   localparam logic [7:0] CELL_RESET     = 8'h00;
   localparam logic [5:0] ODD_CELLS      = 6'h15; // cells 1, 3, 5

   // ----------------------------------------------------------------------
   // channel order codes
   // ----------------------------------------------------------------------
   localparam logic [1:0] ORD_ODD        = 2'h0;
   localparam logic [1:0] ORD_EVEN       = 2'h1;
   localparam logic [1:0] ORD_ODD_EVEN   = 2'h2;
   localparam logic [1:0] ORD_EVEN_ODD   = 2'h3;

   // ----------------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------------
   localparam int         CLK_PERIOD_NS  = 10;
   localparam int         SECOND_NS      = 1000000000;
   localparam int         SECOND_CYCLES  = SECOND_NS / CLK_PERIOD_NS;
   localparam int         MINUTE_SECONDS = 60;

   // ----------------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0]       pwdata;
   } cbt_apb_req_t;

   typedef enum logic [1:0] {ST_IDLE, ST_ODD, ST_EVEN} cbt_state_t;

endpackage

// ==== tb/cbt_monitor.sv ====
// checker on the balancing timer ports
// assumes setup is rewritten only while balancing is idle
`timescale 1ns/1ps
module cbt_monitor (
   input wire logic                          sys_clk,
   input wire logic                          rst,
   input wire cbt_pkg::cbt_apb_req_t         apb_req,
   input wire logic                          pready,
   input wire logic [31:0]                   prdata,
   input wire logic                          pslverr,
   input wire logic                          fault,
   input wire logic                          thermal_shutdown,
   input wire logic [cbt_pkg::CELL_COUNT-1:0] balance_sw
);
   import cbt_pkg::*;
   logic [1:0] order_q;
   logic       stop_q;
   logic       acc;
   logic       bad;
   logic       odd_on;
   logic       even_on;

   // which cell groups have a switch closed
   assign odd_on  = |(balance_sw & ODD_CELLS);
   assign even_on = |(balance_sw & ~ODD_CELLS);

   // completed transfer and unmapped index decode
   assign acc = apb_req.psel && apb_req.penable && pready;
   assign bad = apb_req.paddr[11:2] < IDX_SETUP || apb_req.paddr[11:2] > IDX_STATUS;

   // shadow of the order and stop fields
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         order_q <= 2'h0;
         stop_q  <= 1'b0;
      end else if (acc && apb_req.pwrite && apb_req.paddr[11:2] == IDX_SETUP) begin
         order_q <= apb_req.pwdata[1:0];
         stop_q  <= apb_req.pwdata[SETUP_STOP_BIT];
      end
   end

   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   // ---------------------------------------------------------------
   // bus answers
   // ---------------------------------------------------------------
   apb_wait_a: assert property (apb_req.psel && !apb_req.penable |=> pready)
      else $error("no ready after setup");
   rd_idle_a: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside access");
   bad_addr_a: assert property (acc && bad |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   good_addr_a: assert property (acc && !bad |-> !pslverr && prdata[31:8] == 24'h0)
      else $error("mapped access refused");

   // ---------------------------------------------------------------
   // switch sequencing and halts
   // ---------------------------------------------------------------
   odd_only_a: assert property (order_q == ORD_ODD |-> (balance_sw & ~ODD_CELLS) == 6'h0)
      else $error("even cell on in odd mode");
   even_only_a: assert property (order_q == ORD_EVEN |-> (balance_sw & ODD_CELLS) == 6'h0)
      else $error("odd cell on in even mode");
   one_group_a: assert property (!(odd_on && even_on))
      else $error("both groups on");
   thermal_halt_a: assert property (thermal_shutdown |=> balance_sw == 6'h0)
      else $error("switch on after thermal shutdown");
   fault_halt_a: assert property (fault && stop_q |=> balance_sw == 6'h0)
      else $error("switch on after fault");
endmodule

bind cbt_balance_timer cbt_monitor u_cbt_monitor (
   .sys_clk          (sys_clk),
   .rst              (rst),
   .apb_req          (apb_req),
   .pready           (pready),
   .prdata           (prdata),
   .pslverr          (pslverr),
   .fault            (fault),
   .thermal_shutdown (thermal_shutdown),
   .balance_sw       (balance_sw)
);

// ==== tb/cbt_balance_timer_tb.sv ====
// self-checking bench for the balancing timer
// assumes a wait-free APB slave and a shortened second
`timescale 1ns/1ps
module cbt_balance_timer_tb;
   import cbt_pkg::*;
   localparam int SC = 10;
   logic         sys_clk;
   logic         rst;
   cbt_apb_req_t req;
   logic         pready;
   logic [31:0]  prdata;
   logic         pslverr;
   logic         fault;
   logic         thermal_shutdown;
   logic [5:0]   sw;
   logic [31:0]  rdat;
   logic         rerr;
   int           mismatches;
   int           check_count;

   cbt_balance_timer #(.SEC_CYCLES(SC)) u_cbt_balance_timer (
      .sys_clk          (sys_clk),
      .rst              (rst),
      .apb_req          (req),
      .pready           (pready),
      .prdata           (prdata),
      .pslverr          (pslverr),
      .fault            (fault),
      .thermal_shutdown (thermal_shutdown),
      .balance_sw       (sw)
   );

   // 100 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // one transfer, held until ready is seen at a rising edge
   task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] wd);
      int n;
      @(posedge sys_clk);
      req <= '{1'b1, 1'b0, w, {idx, 2'b00}, wd};
      @(posedge sys_clk);
      req.penable <= 1'b1;
      for (n = 0; pready !== 1'b1; n++) begin
         if (n == 20) begin
            mismatches++;
            final_report();
         end
         @(posedge sys_clk);
      end
      rdat = prdata;
      rerr = pslverr;
      req <= '0;
      #1;
   endtask

   task automatic wr(input logic [9:0] idx, input logic [7:0] d);
      apb(1'b1, idx, {24'h0, d});
   endtask

   task automatic rd(input logic [9:0] idx);
      apb(1'b0, idx, 32'h0);
   endtask

   task automatic wait_cy(input int c);
      repeat (c) @(posedge sys_clk);
      #1;
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_regs();
      for (int i = 0; i < 7; i++) begin
         rd(IDX_SETUP + 10'(i));
         chk("reset value", rdat, 32'h0);
         wr(IDX_SETUP + 10'(i), 8'hf0 + 8'(i));
         rd(IDX_SETUP + 10'(i));
         chk("read back", rdat, 32'hf0 + 32'(i));
      end
      apb(1'b1, IDX_FIRST_CELL, 32'habcd_0012);
      rd(IDX_FIRST_CELL);
      chk("upper bits", rdat, 32'h12);
      apb(1'b1, 10'h10c, 32'h55);
      chk("unmapped wr", 32'(rerr), 32'h1);
      rd(10'h10c);
      chk("unmapped rd", {rdat[30:0], rerr}, 32'h1);
      for (int i = 0; i < 6; i++) wr(IDX_FIRST_CELL + 10'(i), 8'h00);
      $display("test regs done");
   endtask

   task automatic t_span(input logic u, input logic [6:0] t);
      int c;
      c = int'(t) * SC * (u ? 1 : MINUTE_SECONDS);
      wr(IDX_SETUP, {u, 7'h00});
      wr(IDX_FIRST_CELL, {u, t});
      wr(IDX_CTRL, 8'h01);
      chk("sw on", 32'(sw), 32'h1);
      wait_cy(c - 1);
      chk("sw held", 32'(sw), 32'h1);
      wait_cy(1);
      chk("sw off", 32'(sw), 32'h0);
      rd(IDX_STATUS);
      chk("done", rdat & 32'h9, 32'h8);
      $display("test span done");
   endtask

   task automatic t_order();
      logic [1:0] o;
      logic [5:0] f;
      logic [5:0] s;
      wr(IDX_FIRST_CELL, 8'h81);
      wr(IDX_FIRST_CELL + 10'h1, 8'h81);
      for (int k = 0; k < 4; k++) begin
         o = 2'(k);
         f = (o == ORD_ODD || o == ORD_ODD_EVEN) ? 6'h01 : 6'h02;
         s = (o == ORD_ODD_EVEN) ? 6'h02 : (o == ORD_EVEN_ODD) ? 6'h01 : 6'h00;
         wr(IDX_SETUP, {6'h20, o});
         wr(IDX_CTRL, 8'h01);
         chk("first group", 32'(sw), 32'(f));
         wait_cy(SC + 4);
         chk("second group", 32'(sw), 32'(s));
         wait_cy(SC + 4);
         chk("all off", 32'(sw), 32'h0);
      end
      $display("test order done");
   endtask

   // duty slice of one second alternates the groups, odd first
   task automatic t_duty();
      wr(IDX_FIRST_CELL, 8'h82);
      wr(IDX_FIRST_CELL + 10'h1, 8'h82);
      wr(IDX_SETUP, 8'h8a);
      wr(IDX_CTRL, 8'h01);
      wait_cy(4);
      chk("slice 1 odd", 32'(sw), 32'h01);
      wait_cy(10);
      chk("slice 2 even", 32'(sw), 32'h02);
      rd(IDX_STATUS);
      chk("even phase", rdat & 32'h3, 32'h3);
      wait_cy(7);
      chk("slice 3 odd", 32'(sw), 32'h01);
      wait_cy(10);
      chk("slice 4 even", 32'(sw), 32'h02);
      wait_cy(10);
      chk("slices done", 32'(sw), 32'h00);
      $display("test duty done");
   endtask

   task automatic t_fault();
      wr(IDX_SETUP, 8'h80);
      wr(IDX_FIRST_CELL, 8'h85);
      wr(IDX_CTRL, 8'h01);
      @(posedge sys_clk) fault <= 1'b1;
      wait_cy(3);
      chk("fault ignored", 32'(sw), 32'h1);
      @(posedge sys_clk) fault <= 1'b0;
      wr(IDX_CTRL, 8'h02);
      chk("abort", 32'(sw), 32'h0);
      wr(IDX_SETUP, 8'h84);
      wr(IDX_CTRL, 8'h01);
      chk("fault run", 32'(sw), 32'h1);
      @(posedge sys_clk) fault <= 1'b1;
      wait_cy(1);
      chk("fault stop", 32'(sw), 32'h0);
      rd(IDX_STATUS);
      chk("fault flag", rdat & 32'h5, 32'h4);
      wr(IDX_CTRL, 8'h01);
      chk("start refused", 32'(sw), 32'h0);
      @(posedge sys_clk) fault <= 1'b0;
      wr(IDX_SETUP, 8'h80);
      wr(IDX_CTRL, 8'h01);
      chk("thermal run", 32'(sw), 32'h1);
      @(posedge sys_clk) thermal_shutdown <= 1'b1;
      wait_cy(1);
      chk("thermal stop", 32'(sw), 32'h0);
      @(posedge sys_clk) thermal_shutdown <= 1'b0;
      $display("test fault done");
   endtask

   // reset, then every scenario in turn
   initial begin
      rst = 1'b1;
      req = '0;
      fault = 1'b0;
      thermal_shutdown = 1'b0;
      mismatches = 0;
      check_count = 0;
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      t_regs();
      t_span(1'b1, 7'h02);
      t_span(1'b1, 7'h7f);
      t_span(1'b0, 7'h01);
      t_order();
      t_duty();
      t_fault();
      final_report();
   end
endmodule
